// ---- hdl/cic_pkg.sv ----
// Constants and types shared by the core interrupt control block
package cic_pkg;

  // --------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // --------------------------------------------------------------
  localparam logic [9:0] CIC_ICR_IDX_B0 = 10'h00B;
  localparam logic [9:0] CIC_ICR_IDX_B1 = 10'h08B;
  localparam logic [9:0] CIC_ICR_IDX_B2 = 10'h10B;
  localparam logic [9:0] CIC_ICR_IDX_B3 = 10'h18B;
  localparam logic [9:0] CIC_PORT_IDX = 10'h006;
  localparam logic [9:0] CIC_EVT_STAT_IDX = 10'h040;
  localparam logic [9:0] CIC_EVT_CLR_IDX = 10'h041;
  localparam logic [9:0] CIC_EVT_EN_IDX = 10'h042;

  // --------------------------------------------------------------
  // Field positions of interrupt_control
  // --------------------------------------------------------------
  localparam int CIC_GLOBAL_EN_BIT = 7;
  localparam int CIC_PERIPH_EN_BIT = 6;
  localparam int CIC_T0IE_BIT = 5;
  localparam int CIC_EXTIE_BIT = 4;
  localparam int CIC_CHGIE_BIT = 3;
  localparam int CIC_T0IF_BIT = 2;
  localparam int CIC_EXTIF_BIT = 1;
  localparam int CIC_CHGIF_BIT = 0;

  // Event status / clear / enable layout
  localparam int CIC_EVT_W = 3;
  localparam int CIC_EVT_T0_BIT = 0;
  localparam int CIC_EVT_EXT_BIT = 1;
  localparam int CIC_EVT_CHG_BIT = 2;

  // --------------------------------------------------------------
  // Reset values and counts
  // --------------------------------------------------------------
  localparam logic [7:0] CIC_ICR_RST = 8'h00;
  localparam logic [2:0] CIC_EVT_RST = 3'h0;
  localparam logic [2:0] CIC_EVT_EN_RST = 3'h0;
  localparam logic [3:0] CIC_SNAP_RST = 4'h0;
  localparam logic [2:0] CIC_SETTLE_CYCLES = 3'h5;
  localparam logic [2:0] CIC_HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    CIC_SEL_NONE = 3'b000,
    CIC_SEL_ICR = 3'b001,
    CIC_SEL_PORT = 3'b010,
    CIC_SEL_EVT_STAT = 3'b011,
    CIC_SEL_EVT_CLR = 3'b100,
    CIC_SEL_EVT_EN = 3'b101
  } cic_sel_t;

endpackage : cic_pkg

// ---- hdl/cic_pin_sync.sv ----
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/100ps
module cic_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and settled levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic st_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= async_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // Change counts once second and third stage agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_q <= 1'b0;
        end else if (s2_q == s3_q) begin
          st_q <= s3_q;
        end
      end
      assign stable_out[gi] = st_q;
    end
  endgenerate

endmodule : cic_pin_sync

// ---- hdl/cic_core_irq.sv ----
// Core interrupt control register block with AHB-Lite access
//
// How it works
// - The interrupt control register answers at the same offset in all four banks.
// - After reset all eight bits read zero, all bits are R/W.
// - Each flag is set by its event whatever its own enable and the global enable hold.
// - The global enable lets unmasked interrupts reach the core and blocks all when zero.
// - The peripheral enable passes or blocks the peripheral request.
// - The timer0 enable passes or blocks the timer0 overflow interrupt.
// - The external pin enable passes or blocks the external pin interrupt.
// - The port change enable passes or blocks the port change interrupt.
// - The timer0 flag sets on overflow and only software clears it.
// - The external pin flag sets on a pin event and only software clears it.
// - The port change flag sets when any upper port pin changes, software clears it.
// - A standing mismatch keeps setting the change flag until a port read ends it.
`timescale 1ns/100ps
module cic_core_irq
  import cic_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CHG_W = 4,
  parameter logic EXT_RISING = 1'b1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event sources
  input wire logic timer0_overflow,
  input wire logic periph_irq_req,
  input wire logic ext_irq_pin,
  input wire logic [CHG_W-1:0] change_sense_pins,
  // Requests
  output logic core_irq_req,
  output logic irq
);

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  function automatic cic_sel_t decode_sel(input logic [9:0] idx);
    case (idx)
      CIC_ICR_IDX_B0, CIC_ICR_IDX_B1,
      CIC_ICR_IDX_B2, CIC_ICR_IDX_B3: decode_sel = CIC_SEL_ICR;
      CIC_PORT_IDX: decode_sel = CIC_SEL_PORT;
      CIC_EVT_STAT_IDX: decode_sel = CIC_SEL_EVT_STAT;
      CIC_EVT_CLR_IDX: decode_sel = CIC_SEL_EVT_CLR;
      CIC_EVT_EN_IDX: decode_sel = CIC_SEL_EVT_EN;
      default: decode_sel = CIC_SEL_NONE;
    endcase
  endfunction : decode_sel

  logic acc;
  logic [9:0] acc_idx;
  cic_sel_t acc_sel;
  cic_sel_t wr_sel_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_word;
  logic rd_port;
  logic [7:0] icr_q;
  logic [CIC_EVT_W-1:0] evt_q;
  logic [CIC_EVT_W-1:0] evt_en_q;
  logic [CIC_EVT_W-1:0] evt_set;
  logic [CIC_EVT_W-1:0] evt_clr;
  logic [CHG_W:0] pins_s;
  logic [CHG_W-1:0] snap_q;
  logic ext_prev_q;
  logic [2:0] settle_q;
  logic armed;
  logic ext_evt;
  logic mismatch;
  logic mismatch_q;
  logic req_d;
  logic core_irq_q;
  logic irq_q;
  logic first_q;

  assign acc = hsel & hready & htrans[1];
  assign acc_idx = haddr[11:2];
  assign acc_sel = decode_sel(acc_idx);
  assign rd_port = acc & ~hwrite & (acc_sel == CIC_SEL_PORT);

  // --------------------------------------------------------------
  // Bus address phase and read data
  // --------------------------------------------------------------
  always_comb begin
    case (acc_sel)
      CIC_SEL_ICR: rd_word = {24'h000000, icr_q};
      CIC_SEL_PORT: rd_word = {24'h000000, pins_s[CHG_W:1], 4'h0};
      CIC_SEL_EVT_STAT: rd_word = {29'h00000000, evt_q};
      CIC_SEL_EVT_EN: rd_word = {29'h00000000, evt_en_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_sel_q <= CIC_SEL_NONE;
    end else if (acc && hwrite && hsize == CIC_HSIZE_WORD) begin
      wr_sel_q <= acc_sel;
    end else begin
      wr_sel_q <= CIC_SEL_NONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata_q <= rd_word;
    end else begin
      hrdata_q <= 32'h00000000;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // --------------------------------------------------------------
  // Pin synchronisers and event detection
  // --------------------------------------------------------------
  cic_pin_sync #(
    .WIDTH(CHG_W + 1)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .async_in({change_sense_pins, ext_irq_pin}),
    .stable_out(pins_s)
  );

  // Hold off detection until the synchronisers show real pin levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_q <= 3'h0;
    end else if (settle_q != CIC_SETTLE_CYCLES) begin
      settle_q <= settle_q + 3'h1;
    end
  end
  assign armed = (settle_q == CIC_SETTLE_CYCLES);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= pins_s[0];
    end
  end
  assign ext_evt = armed & (EXT_RISING ? (pins_s[0] & ~ext_prev_q)
                                       : (~pins_s[0] & ext_prev_q));

  // Copy of the upper pins, retaken on every port read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_q <= CIC_SNAP_RST;
    end else if (!armed || rd_port) begin
      snap_q <= pins_s[CHG_W:1];
    end
  end
  assign mismatch = armed & (pins_s[CHG_W:1] != snap_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= mismatch;
    end
  end

  // --------------------------------------------------------------
  // Interrupt control register
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      icr_q <= CIC_ICR_RST;
    end else if (wr_sel_q == CIC_SEL_ICR) begin
      icr_q <= hwdata[7:0];
      // Event in the write cycle wins over a written zero
      if (timer0_overflow) icr_q[CIC_T0IF_BIT] <= 1'b1;
      if (ext_evt) icr_q[CIC_EXTIF_BIT] <= 1'b1;
      if (mismatch) icr_q[CIC_CHGIF_BIT] <= 1'b1;
    end else begin
      // Flags ignore every enable bit
      if (timer0_overflow) icr_q[CIC_T0IF_BIT] <= 1'b1;
      if (ext_evt) icr_q[CIC_EXTIF_BIT] <= 1'b1;
      if (mismatch) icr_q[CIC_CHGIF_BIT] <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Event status, clear and enable
  // --------------------------------------------------------------
  assign evt_set = {mismatch & ~mismatch_q, ext_evt, timer0_overflow};
  assign evt_clr = (wr_sel_q == CIC_SEL_EVT_CLR) ? hwdata[CIC_EVT_W-1:0] : CIC_EVT_RST;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_q <= CIC_EVT_RST;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en_q <= CIC_EVT_EN_RST;
    end else if (wr_sel_q == CIC_SEL_EVT_EN) begin
      evt_en_q <= hwdata[CIC_EVT_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // Request outputs
  // --------------------------------------------------------------
  always_comb begin
    req_d = icr_q[CIC_GLOBAL_EN_BIT] & (
      (icr_q[CIC_T0IE_BIT] & icr_q[CIC_T0IF_BIT]) |
      (icr_q[CIC_EXTIE_BIT] & icr_q[CIC_EXTIF_BIT]) |
      (icr_q[CIC_CHGIE_BIT] & icr_q[CIC_CHGIF_BIT]) |
      (icr_q[CIC_PERIPH_EN_BIT] & periph_irq_req));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      core_irq_q <= req_d;
      irq_q <= |(evt_q & evt_en_q);
    end
  end

  assign core_irq_req = core_irq_q;
  assign irq = irq_q;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  a_reset_low_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    first_q |-> (icr_q[7:1] == 7'h00))
    else $error("control bits not zero after reset");

  a_alias_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (acc && !hwrite && acc_sel == CIC_SEL_ICR)
      |=> (hrdata == {24'h000000, $past(icr_q)}))
    else $error("bank alias read does not return control register");

  a_timer_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer0_overflow |=> icr_q[CIC_T0IF_BIT] [*2]
      or ($past(wr_sel_q) == CIC_SEL_ICR)
      or (wr_sel_q == CIC_SEL_ICR))
    else $error("timer0 flag not set or not held");

  a_ext_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ext_evt |=> icr_q[CIC_EXTIF_BIT])
    else $error("external pin flag not set");

  a_change_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mismatch |=> icr_q[CIC_CHGIF_BIT])
    else $error("change flag not kept set during mismatch");

  a_global_block: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !icr_q[CIC_GLOBAL_EN_BIT] |=> !core_irq_req)
    else $error("request with global enable clear");

  a_periph_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_GLOBAL_EN_BIT] && icr_q[CIC_PERIPH_EN_BIT] && periph_irq_req)
      |=> core_irq_req)
    else $error("peripheral request not passed");

  a_timer_request: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_GLOBAL_EN_BIT] && icr_q[CIC_T0IE_BIT] && icr_q[CIC_T0IF_BIT])
      |=> core_irq_req)
    else $error("enabled timer0 flag gives no request");

  a_no_request: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!(icr_q[CIC_T0IE_BIT] && icr_q[CIC_T0IF_BIT])
      && !(icr_q[CIC_EXTIE_BIT] && icr_q[CIC_EXTIF_BIT])
      && !(icr_q[CIC_CHGIE_BIT] && icr_q[CIC_CHGIF_BIT])
      && !(icr_q[CIC_PERIPH_EN_BIT] && periph_irq_req)) |=> !core_irq_req)
    else $error("request without enabled source");

  a_snap_on_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (armed && rd_port) |=> (snap_q == $past(pins_s[CHG_W:1])))
    else $error("port read does not retake pin copy");

  a_event_irq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (|(evt_q & evt_en_q)) |=> irq)
    else $error("enabled event status gives no interrupt");

  a_ext_request: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_GLOBAL_EN_BIT] && icr_q[CIC_EXTIE_BIT] && icr_q[CIC_EXTIF_BIT])
      |=> core_irq_req)
    else $error("enabled external pin flag gives no request");

  a_change_request: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_GLOBAL_EN_BIT] && icr_q[CIC_CHGIE_BIT] && icr_q[CIC_CHGIF_BIT])
      |=> core_irq_req)
    else $error("enabled change flag gives no request");

  a_ext_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_EXTIF_BIT] && wr_sel_q != CIC_SEL_ICR) |=> icr_q[CIC_EXTIF_BIT])
    else $error("external pin flag cleared without a write");

  a_change_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (icr_q[CIC_CHGIF_BIT] && wr_sel_q != CIC_SEL_ICR) |=> icr_q[CIC_CHGIF_BIT])
    else $error("change flag cleared without a write");

  a_flag_unmasked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ext_evt && !icr_q[CIC_GLOBAL_EN_BIT] && !icr_q[CIC_EXTIE_BIT])
      |=> icr_q[CIC_EXTIF_BIT])
    else $error("masked external pin event sets no flag");

  a_read_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(acc && !hwrite) |=> (hrdata == 32'h00000000))
    else $error("read data not zero outside a read");

endmodule : cic_core_irq

// ---- sim/cic_core_model.sv ----
// Processor core model that counts interrupt entries
`timescale 1ns/100ps
module cic_core_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request from the block and entry count
  input wire logic core_irq_req,
  output logic [7:0] entries
);
  logic req_q;

  // One entry per rising request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 1'b0;
      entries <= 8'h00;
    end else begin
      req_q <= core_irq_req;
      if (core_irq_req && !req_q) begin
        entries <= entries + 8'h01;
      end
    end
  end
endmodule : cic_core_model

// ---- sim/test_core_interrupt_control.sv ----
// Self-checking bench for the core interrupt control block
`timescale 1ns/100ps
module test_core_interrupt_control import cic_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hready, timer0_overflow, periph_irq_req, ext_irq_pin, p;
  logic hreadyout, hresp, core_irq_req, irq;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [3:0] change_sense_pins;
  logic [7:0] seed, v, entries, e0;
  logic [9:0] bank [4];
  logic [8:0] corner [8];
  int fails, tests_run, cyc;

  assign hready = hreadyout;

  cic_core_irq dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .timer0_overflow, .periph_irq_req,
    .ext_irq_pin, .change_sense_pins, .core_irq_req, .irq);
  cic_core_model core (.hclk, .hresetn, .core_irq_req, .entries);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic exp_req(input logic [7:0] r, input logic pr);
    return r[7] & ((r[5] & r[2]) | (r[4] & r[1]) | (r[3] & r[0]) | (r[6] & pr));
  endfunction : exp_req

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Single word transfer; read data is taken at the edge ending the data phase
  task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {idx, 2'b00};
    hsize <= CIC_HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : bus

  task automatic results();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 12'h000;
    hsize = CIC_HSIZE_WORD;
    hwdata = 32'h0;
    timer0_overflow = 1'b0;
    periph_irq_req = 1'b0;
    ext_irq_pin = 1'b0;
    change_sense_pins = 4'h0;
    seed = 8'h1A;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    bank = '{CIC_ICR_IDX_B0, CIC_ICR_IDX_B1, CIC_ICR_IDX_B2, CIC_ICR_IDX_B3};
    corner = '{9'h0A4, 9'h024, 9'h084, 9'h092, 9'h089, 9'h081, 9'h1C0, 9'h180};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // ------------------------------------------------------------
    // Reset value, bank aliasing and request gating
    // ------------------------------------------------------------
    for (int i = 0; i < 4; i++) begin
      bus(bank[i], 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    for (int i = 0; i < 32; i++) begin
      if (i < 8) begin
        {p, v} = corner[i];
      end else begin
        seed = lfsr(seed);
        v = seed;
        seed = lfsr(seed);
        p = seed[0];
      end
      periph_irq_req <= p;
      bus(bank[i % 4], 1'b1, {24'h0, v});
      tick(2);
      check(core_irq_req, exp_req(v, p));
      bus(bank[(i + 1) % 4], 1'b0, 32'h0);
      check(rd, {24'h0, v});
    end
    periph_irq_req <= 1'b0;
    // ------------------------------------------------------------
    // Timer overflow, event status, enable and clear
    // ------------------------------------------------------------
    bus(bank[0], 1'b1, 32'h0);
    bus(CIC_EVT_CLR_IDX, 1'b1, 32'h7);
    bus(bank[1], 1'b1, 32'hA0);
    e0 = entries;
    timer0_overflow <= 1'b1;
    @(posedge hclk);
    timer0_overflow <= 1'b0;
    tick(3);
    check(core_irq_req, 1'b1);
    check(entries, e0 + 8'h01);
    tick(20);
    bus(bank[2], 1'b0, 32'h0);
    check(rd, 32'hA4);
    bus(CIC_EVT_STAT_IDX, 1'b0, 32'h0);
    check(rd, 32'h1);
    bus(CIC_EVT_EN_IDX, 1'b1, 32'h1);
    tick(2);
    check(irq, 1'b1);
    bus(CIC_EVT_EN_IDX, 1'b1, 32'h0);
    tick(2);
    check(irq, 1'b0);
    bus(CIC_EVT_EN_IDX, 1'b1, 32'h1);
    bus(CIC_EVT_CLR_IDX, 1'b1, 32'h1);
    tick(2);
    check(irq, 1'b0);
    bus(CIC_EVT_STAT_IDX, 1'b0, 32'h0);
    check(rd, 32'h0);
    bus(bank[0], 1'b1, 32'h0);
    bus(bank[3], 1'b0, 32'h0);
    check(rd, 32'h0);
    // ------------------------------------------------------------
    // External pin edge with every interrupt control enable off
    // ------------------------------------------------------------
    ext_irq_pin <= 1'b1;
    tick(12);
    bus(bank[3], 1'b0, 32'h0);
    check(rd, 32'h2);
    check(core_irq_req, 1'b0);
    ext_irq_pin <= 1'b0;
    tick(12);
    bus(bank[0], 1'b1, 32'h0);
    bus(bank[1], 1'b0, 32'h0);
    check(rd, 32'h0);
    // ------------------------------------------------------------
    // Each change pin, standing mismatch, port read
    // ------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      change_sense_pins <= change_sense_pins ^ (4'h1 << k);
      tick(12);
      bus(bank[k], 1'b0, 32'h0);
      check(rd, 32'h1);
      bus(bank[0], 1'b1, 32'h0);
      tick(3);
      bus(bank[1], 1'b0, 32'h0);
      check(rd, 32'h1);
      bus(CIC_PORT_IDX, 1'b0, 32'h0);
      check(rd, {24'h0, change_sense_pins, 4'h0});
      bus(bank[2], 1'b1, 32'h0);
      bus(bank[3], 1'b0, 32'h0);
      check(rd, 32'h0);
    end
    bus(10'h3FF, 1'b1, 32'hFF);
    bus(10'h3FF, 1'b0, 32'h0);
    check(rd, 32'h0);
    // ------------------------------------------------------------
    // Reset in mid-run
    // ------------------------------------------------------------
    change_sense_pins <= 4'h0;
    bus(bank[0], 1'b1, 32'hF8);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    bus(bank[1], 1'b0, 32'h0);
    check(rd, 32'h0);
    results();
  end
endmodule : test_core_interrupt_control
